// file: include/mct_map.svh
// Purpose: register offsets, field positions and constants of the match/capture timer
// Assumes: 32-bit APB, one aligned word per register
// Notes: one line per rule below
`ifndef MCT_MAP_SVH
`define MCT_MAP_SVH
`define MCT_OFS_CTRL 12'h000
`define MCT_OFS_COUNT 12'h004
`define MCT_OFS_PRESC 12'h008
`define MCT_OFS_PCOUNT 12'h00C
`define MCT_OFS_MCTRL 12'h010
`define MCT_OFS_CCTRL 12'h014
`define MCT_OFS_EMR 12'h018
`define MCT_OFS_PWMC 12'h01C
`define MCT_OFS_STAT 12'h020
`define MCT_OFS_MASK 12'h024
`define MCT_OFS_MATCH0 12'h030
`define MCT_OFS_MATCH1 12'h034
`define MCT_OFS_MATCH3 12'h03C
`define MCT_OFS_CAP0 12'h040
`define MCT_OFS_CAP1 12'h044
`define MCT_OFS_CAP2 12'h048
`define MCT_OFS_OUTS 12'h050
// ctrl bits
`define MCT_CTRL_EN 0
`define MCT_CTRL_RST 1
`define MCT_CTRL_EXT 2
// shadow reload enable bit in pwmc, pwm enables in bits 2:0 (bit 3 is stored but unused)
`define MCT_PWMC_SHD 4
// capture control: 3 bits per channel at 3*ch, rise/fall/irq enable; clear-enable at 9, source at 10
`define MCT_CCTRL_CLREN 9
`define MCT_CCTRL_CLRSRC 10
// status: match flags 3:0, capture flags 6:4
`define MCT_STAT_CAP 4
`define MCT_NUM_MATCH 4
`define MCT_NUM_CAP 3
`define MCT_ZERO32 32'h0000_0000
`define MCT_ONE32 32'h0000_0001
`endif

// file: include/mct_pkg.sv
// Purpose: shared types of the match/capture timer
// Assumes: constants come from mct_map.svh
// Notes: none
package mct_pkg;
   // emr action encoding per output
   typedef enum logic [1:0] {MCT_ACT_NONE, MCT_ACT_LOW, MCT_ACT_HIGH, MCT_ACT_TOG} mct_act_t;
   typedef struct packed {
      logic [2:0] act_int;
      logic [2:0] act_rst;
      logic [2:0] act_stop;
   } mct_mctrl_t;
   typedef struct packed {
      logic [11:0] addr;
      logic wr;
      logic rd;
      logic [31:0] wdata;
   } mct_req_t;
endpackage

// file: sim/tb.sv
// Purpose: self-checking bench of the match/capture timer over apb
// Assumes: zero-wait apb slave, pins settle three pclk after an edge
// Notes: pwm duty is measured over two whole periods, so the phase does not matter
`include "mct_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mct_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ext_count = 1'b0;
   logic [2:0] cap_in = 3'h0;
   logic [3:0] match_out;
   logic irq;
   logic [31:0] rdat;
   logic rerr;
   int n_errors = 0;
   int n_compared = 0;

   mct_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_count(ext_count), .cap_in(cap_in), .match_out(match_out),
      .irq(irq));

   always #20 pclk = ~pclk;

   // ----------------------------------------
   // bus and compare tasks
   // ----------------------------------------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // values read just after the edge are those sampled at it; only the watchdog ends a stall
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdat, exp, "read data");
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic wait_irq();
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (irq !== 1'b1 && k < 500);
      chk({31'h0, irq}, 32'h1, "irq raised");
   endtask

   task automatic cap_pulse(input int ch);
      cap_in[ch] <= 1'b1;
      repeat (6) @(posedge pclk);
      cap_in[ch] <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask

   // high cycles of match output 1 over a window of 20 clocks
   task automatic duty(input logic [31:0] exp);
      logic [31:0] n;
      n = 32'h0000_0000;
      repeat (20) begin
         @(posedge pclk);
         n = n + {31'h0, match_out[1]};
      end
      chk(n, exp, "pwm high cycles");
   endtask

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`MCT_OFS_CTRL, 32'h0000_0000);
      rd(`MCT_OFS_COUNT, 32'h0000_0000);
      rd(`MCT_OFS_STAT, 32'h0000_0000);
      apb(1'b0, 12'h0FC, 32'h0000_0000);
      chk({31'h0, rerr}, 32'h1, "unmapped error");
      chk(rdat, 32'h0000_0000, "unmapped read data");
      $display("test reset done");
      // stop on match with output driven high
      wr(`MCT_OFS_PRESC, 32'h0000_0001);
      wr(`MCT_OFS_MATCH0, 32'h0000_0005);
      wr(`MCT_OFS_MCTRL, 32'h0000_0041);
      wr(`MCT_OFS_EMR, 32'h0000_0002);
      wr(`MCT_OFS_MASK, 32'h0000_007F);
      wr(`MCT_OFS_CTRL, 32'h0000_0001);
      wait_irq();
      rd(`MCT_OFS_COUNT, 32'h0000_0005);
      rd(`MCT_OFS_CTRL, 32'h0000_0000);
      rd(`MCT_OFS_STAT, 32'h0000_0001);
      chk({28'h0, match_out}, 32'h1, "out0 high");
      rd(`MCT_OFS_COUNT, 32'h0000_0005);
      wr(`MCT_OFS_STAT, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      $display("test stop done");
      // reset on match with toggling output
      wr(`MCT_OFS_COUNT, 32'h0000_0000);
      wr(`MCT_OFS_MATCH1, 32'h0000_0003);
      wr(`MCT_OFS_MCTRL, 32'h0000_0090);
      wr(`MCT_OFS_EMR, 32'h0000_000E);
      wr(`MCT_OFS_CTRL, 32'h0000_0001);
      wait_irq();
      chk({28'h0, match_out}, 32'h3, "out1 toggled");
      repeat (40) @(posedge pclk);
      wr(`MCT_OFS_CTRL, 32'h0000_0000);
      apb(1'b0, `MCT_OFS_COUNT, 32'h0000_0000);
      chk({31'h0, rdat <= 32'h0000_0003}, 32'h1, "count wraps at 3");
      wr(`MCT_OFS_STAT, 32'h0000_007F);
      wr(`MCT_OFS_MCTRL, 32'h0000_0000);
      $display("test reset on match done");
      // captures with the counter held still
      wr(`MCT_OFS_COUNT, 32'h0000_1234);
      wr(`MCT_OFS_CCTRL, 32'h0000_0005);
      cap_pulse(0);
      rd(`MCT_OFS_CAP0, 32'h0000_1234);
      rd(`MCT_OFS_STAT, 32'h0000_0010);
      chk({31'h0, irq}, 32'h1, "capture irq");
      wr(`MCT_OFS_STAT, 32'h0000_0010);
      wr(`MCT_OFS_COUNT, 32'h0000_0077);
      wr(`MCT_OFS_CCTRL, 32'h0000_0608);
      cap_pulse(1);
      rd(`MCT_OFS_CAP1, 32'h0000_0077);
      rd(`MCT_OFS_COUNT, 32'h0000_0000);
      rd(`MCT_OFS_PCOUNT, 32'h0000_0000);
      // falling edge capture while masked
      wr(`MCT_OFS_STAT, 32'h0000_007F);
      wr(`MCT_OFS_MASK, 32'h0000_0000);
      wr(`MCT_OFS_COUNT, 32'h0000_0099);
      wr(`MCT_OFS_CCTRL, 32'h0000_0180);
      cap_pulse(2);
      chk({31'h0, irq}, 32'h0, "masked irq");
      rd(`MCT_OFS_CAP2, 32'h0000_0099);
      rd(`MCT_OFS_STAT, 32'h0000_0040);
      wr(`MCT_OFS_MASK, 32'h0000_007F);
      // irq is registered from the mask as it stood, so it follows one edge later
      @(posedge pclk);
      chk({31'h0, irq}, 32'h1, "unmasked irq");
      wr(`MCT_OFS_STAT, 32'h0000_0040);
      $display("test capture done");
      // external count pin
      wr(`MCT_OFS_CCTRL, 32'h0000_0000);
      wr(`MCT_OFS_PRESC, 32'h0000_0000);
      wr(`MCT_OFS_COUNT, 32'h0000_0000);
      wr(`MCT_OFS_CTRL, 32'h0000_0005);
      repeat (4) begin
         ext_count <= 1'b1;
         repeat (5) @(posedge pclk);
         ext_count <= 1'b0;
         repeat (5) @(posedge pclk);
      end
      rd(`MCT_OFS_COUNT, 32'h0000_0004);
      $display("test external count done");
      // single-edge pwm: period 10 set by match3, duty by match1 through its shadow
      wr(`MCT_OFS_CTRL, 32'h0000_0002);
      wr(`MCT_OFS_EMR, 32'h0000_0000);
      wr(`MCT_OFS_MCTRL, 32'h0000_0400);
      wr(`MCT_OFS_MATCH3, 32'h0000_0009);
      wr(`MCT_OFS_MATCH1, 32'h0000_0004);
      wr(`MCT_OFS_PWMC, 32'h0000_0012);
      wr(`MCT_OFS_CTRL, 32'h0000_0001);
      repeat (12) @(posedge pclk);
      duty(32'h0000_000A);
      wr(`MCT_OFS_MATCH1, 32'h0000_0007);
      rd(`MCT_OFS_MATCH1, 32'h0000_0007);
      repeat (12) @(posedge pclk);
      duty(32'h0000_0004);
      wr(`MCT_OFS_CTRL, 32'h0000_0000);
      $display("test pwm done");
      complete_run();
   end

   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      complete_run();
   end
endmodule

// file: src/mct_sync.sv
// Purpose: two-stage synchroniser with rising/falling edge detect behind it
// Assumes: d is asynchronous to pclk
// Notes: edges are taken from stages two and three only
module mct_sync
   import mct_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic d,
   output logic rise,
   output logic fall
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   assign rise = s2_r & ~s3_r;
   assign fall = ~s2_r & s3_r;
endmodule

// file: src/mct_timer.sv
// Purpose: 32-bit timer/counter with prescaler, four matches, three captures, apb slave
// Assumes: single clock pclk, async active-low presetn, zero-wait apb
// Notes: external count and capture pins pass two flip-flops before use
//
// The register addresses and the APB register port are this design's own decisions.
`include "mct_map.svh"
module mct_timer
   import mct_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_count,
   input wire logic [2:0] cap_in,
   output logic [3:0] match_out,
   output logic irq
);
   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [2:0] ctrl_r;
   logic [31:0] count_r;
   logic [31:0] presc_r;
   logic [31:0] pcount_r;
   logic [11:0] mctrl_r;
   logic [10:0] cctrl_r;
   logic [7:0] emr_r;
   logic [4:0] pwmc_r;
   logic [6:0] stat_r;
   logic [6:0] mask_r;
   logic [31:0] match_r [4];
   logic [31:0] shadow_r [4];
   logic [31:0] cap_r [3];
   logic [3:0] mout_r;
   logic [31:0] prdata_r;
   logic irq_r;
   mct_req_t req;

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   assign req.addr = paddr;
   assign req.wr = psel & penable & pwrite;
   assign req.rd = psel & ~penable & ~pwrite;
   assign req.wdata = pwdata;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   wire in_match = (paddr[11:4] == `MCT_OFS_MATCH0 >> 4);
   wire in_cap = (paddr[11:4] == `MCT_OFS_CAP0 >> 4) & (paddr[3:2] != 2'h3);
   wire [1:0] widx = paddr[3:2];
   wire mapped = hit(paddr, `MCT_OFS_CTRL) | hit(paddr, `MCT_OFS_COUNT)
      | hit(paddr, `MCT_OFS_PRESC) | hit(paddr, `MCT_OFS_PCOUNT)
      | hit(paddr, `MCT_OFS_MCTRL) | hit(paddr, `MCT_OFS_CCTRL)
      | hit(paddr, `MCT_OFS_EMR) | hit(paddr, `MCT_OFS_PWMC)
      | hit(paddr, `MCT_OFS_STAT) | hit(paddr, `MCT_OFS_MASK)
      | hit(paddr, `MCT_OFS_OUTS) | in_match | in_cap;
   wire bad = ~mapped | (paddr[1:0] != 2'h0);
   wire wr_ok = req.wr & ~bad;

   // ---------------------------------------------------------------
   // pin inputs
   // ---------------------------------------------------------------
   logic ext_rise;
   logic [2:0] cap_rise;
   logic [2:0] cap_fall;
   mct_sync u_ext (.pclk(pclk), .presetn(presetn), .d(ext_count), .rise(ext_rise), .fall());
   genvar g;
   generate
      for (g = 0; g < `MCT_NUM_CAP; g++) begin : g_cap
         mct_sync u_cs (.pclk(pclk), .presetn(presetn), .d(cap_in[g]),
            .rise(cap_rise[g]), .fall(cap_fall[g]));
      end
   endgenerate

   // ---------------------------------------------------------------
   // counting
   // ---------------------------------------------------------------
   mct_mctrl_t mc;
   assign mc = mctrl_r[8:0];
   wire running = ctrl_r[`MCT_CTRL_EN] & ~ctrl_r[`MCT_CTRL_RST];
   wire tick_src = ctrl_r[`MCT_CTRL_EXT] ? ext_rise : 1'b1;
   wire tick = running & tick_src;
   wire pre_tc = tick & (pcount_r == presc_r);
   wire [3:0] mhit;
   wire [2:0] cev;
   generate
      for (g = 0; g < `MCT_NUM_MATCH; g++) begin : g_mhit
         assign mhit[g] = pre_tc & (count_r == match_r[g]);
      end
      for (g = 0; g < `MCT_NUM_CAP; g++) begin : g_cev
         assign cev[g] = (cctrl_r[3*g] & cap_rise[g]) | (cctrl_r[3*g+1] & cap_fall[g]);
      end
   endgenerate
   // three lower matches have 3-bit action fields; match3 uses mctrl bits 11:9
   wire [3:0] m_int = {mctrl_r[9], mc.act_int};
   wire [3:0] m_rst = {mctrl_r[10], mc.act_rst};
   wire [3:0] m_stop = {mctrl_r[11], mc.act_stop};
   wire do_stop = |(mhit & m_stop);
   wire do_rst = |(mhit & m_rst);
   wire do_cclr = cctrl_r[`MCT_CCTRL_CLREN] & (cctrl_r[`MCT_CCTRL_CLRSRC] ? cev[1] : cev[0]);
   wire wr_count = wr_ok & hit(paddr, `MCT_OFS_COUNT);
   // stop leaves the count on the match value, so software reads where it halted
   wire [31:0] count_nxt = do_rst ? `MCT_ZERO32
      : (do_stop ? count_r : count_r + `MCT_ONE32);
   // shadow load at period end, or any time the counter is not running
   wire shd_load = ~pwmc_r[`MCT_PWMC_SHD] | do_rst | ~running;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcount_r <= `MCT_ZERO32;
         count_r <= `MCT_ZERO32;
      end else if (ctrl_r[`MCT_CTRL_RST] | do_cclr) begin
         pcount_r <= `MCT_ZERO32;
         count_r <= `MCT_ZERO32;
      end else if (wr_count) begin
         count_r <= pwdata;
      end else if (pre_tc) begin
         pcount_r <= `MCT_ZERO32;
         count_r <= count_nxt;
      end else if (tick) begin
         pcount_r <= pcount_r + `MCT_ONE32;
      end
   end

   // ---------------------------------------------------------------
   // match, shadow, capture, outputs
   // ---------------------------------------------------------------
   generate
      for (g = 0; g < `MCT_NUM_MATCH; g++) begin : g_m
         wire wr_m = wr_ok & in_match & (widx == g);
         mct_act_t act;
         assign act = mct_act_t'(emr_r[2*g+1:2*g]);
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               shadow_r[g] <= `MCT_ZERO32;
               match_r[g] <= `MCT_ZERO32;
            end else begin
               if (wr_m) begin
                  shadow_r[g] <= pwdata;
               end
               if (shd_load) begin
                  match_r[g] <= wr_m ? pwdata : shadow_r[g];
               end
            end
         end
         // output action on match; pwm outputs set at match, clear at period
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mout_r[g] <= 1'b0;
            end else if (pwmc_r[g] && g != 3) begin
               if (mhit[g]) begin
                  mout_r[g] <= 1'b1;
               end else if (mhit[3]) begin
                  mout_r[g] <= 1'b0;
               end
            end else if (mhit[g]) begin
               unique case (act)
                  MCT_ACT_NONE: mout_r[g] <= mout_r[g];
                  MCT_ACT_LOW: mout_r[g] <= 1'b0;
                  MCT_ACT_HIGH: mout_r[g] <= 1'b1;
                  MCT_ACT_TOG: mout_r[g] <= ~mout_r[g];
               endcase
            end
         end
      end
      for (g = 0; g < `MCT_NUM_CAP; g++) begin : g_c
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cap_r[g] <= `MCT_ZERO32;
            end else if (cev[g]) begin
               cap_r[g] <= count_r;
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // control registers and flags
   // ---------------------------------------------------------------
   wire [6:0] ev = {cev & {cctrl_r[8], cctrl_r[5], cctrl_r[2]}, mhit & m_int};
   wire [6:0] w1c = (wr_ok & hit(paddr, `MCT_OFS_STAT)) ? pwdata[6:0] : 7'h00;
   wire [6:0] stat_nxt = (stat_r & ~w1c) | ev;
   wire [2:0] ctrl_nxt = (wr_ok & hit(paddr, `MCT_OFS_CTRL)) ? pwdata[2:0] : ctrl_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 3'h0;
         presc_r <= `MCT_ZERO32;
         mctrl_r <= 12'h000;
         cctrl_r <= 11'h000;
         emr_r <= 8'h00;
         pwmc_r <= 5'h00;
         mask_r <= 7'h00;
         stat_r <= 7'h00;
         irq_r <= 1'b0;
      end else begin
         // stop clears the enable so software sees the halt
         ctrl_r <= do_stop ? (ctrl_nxt & ~3'h1) : ctrl_nxt;
         if (wr_ok & hit(paddr, `MCT_OFS_PRESC)) presc_r <= pwdata;
         if (wr_ok & hit(paddr, `MCT_OFS_MCTRL)) mctrl_r <= pwdata[11:0];
         if (wr_ok & hit(paddr, `MCT_OFS_CCTRL)) cctrl_r <= pwdata[10:0];
         if (wr_ok & hit(paddr, `MCT_OFS_EMR)) emr_r <= pwdata[7:0];
         if (wr_ok & hit(paddr, `MCT_OFS_PWMC)) pwmc_r <= pwdata[4:0];
         if (wr_ok & hit(paddr, `MCT_OFS_MASK)) mask_r <= pwdata[6:0];
         stat_r <= stat_nxt;
         irq_r <= |(stat_nxt & mask_r);
      end
   end

   // ---------------------------------------------------------------
   // read path
   // ---------------------------------------------------------------
   logic [31:0] rmux;
   always_comb begin
      rmux = `MCT_ZERO32;
      if (in_match) rmux = shadow_r[widx];
      if (in_cap) rmux = cap_r[widx];
      unique case (paddr)
         `MCT_OFS_CTRL: rmux = {29'h0, ctrl_r};
         `MCT_OFS_COUNT: rmux = count_r;
         `MCT_OFS_PRESC: rmux = presc_r;
         `MCT_OFS_PCOUNT: rmux = pcount_r;
         `MCT_OFS_MCTRL: rmux = {20'h0, mctrl_r};
         `MCT_OFS_CCTRL: rmux = {21'h0, cctrl_r};
         `MCT_OFS_EMR: rmux = {24'h0, emr_r};
         `MCT_OFS_PWMC: rmux = {27'h0, pwmc_r};
         `MCT_OFS_STAT: rmux = {25'h0, stat_r};
         `MCT_OFS_MASK: rmux = {25'h0, mask_r};
         `MCT_OFS_OUTS: rmux = {28'h0, mout_r};
         default: ;
      endcase
   end

   // read data captured in setup so the access phase sees a register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= `MCT_ZERO32;
      end else if (req.rd) begin
         prdata_r <= bad ? `MCT_ZERO32 : rmux;
      end
   end

   logic err_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_r <= 1'b0;
      end else begin
         err_r <= psel & ~penable & bad;
      end
   end

   assign prdata = prdata_r;
   assign pready = 1'b1;
   assign pslverr = err_r;
   assign match_out = mout_r;
   assign irq = irq_r;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_tc;
      pre_tc && !do_rst && !do_stop && !do_cclr && !ctrl_r[`MCT_CTRL_RST] && !wr_count;
   endsequence
   // period end of pwm output 1 without its own match in the same tick
   sequence s_pwm_end;
      pwmc_r[1] && mhit[3] && !mhit[1];
   endsequence
   // prescaler step that is not terminal: only the prescaler moves
   sequence s_pre_wait;
      tick && !pre_tc && !ctrl_r[`MCT_CTRL_RST] && !do_cclr && !wr_count;
   endsequence
   // stop without a reset, clear or write competing for the count
   sequence s_stop_only;
      do_stop && !do_rst && !do_cclr && !ctrl_r[`MCT_CTRL_RST] && !wr_count;
   endsequence
   // shadow transfer with no bus write to a match word in the same cycle
   sequence s_shd_copy;
      shd_load && !(wr_ok && in_match);
   endsequence
   a_count_advance: assert property (@(posedge pclk) disable iff (!presetn)
      s_tc |=> count_r == $past(count_r) + `MCT_ONE32) else $error("count missed advance");
   a_ext_source: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_r[`MCT_CTRL_EXT] && !ext_rise) |-> !tick) else $error("tick without ext edge");
   a_cap_snap: assert property (@(posedge pclk) disable iff (!presetn)
      cev[0] |=> cap_r[0] == $past(count_r)) else $error("capture value wrong");
   a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (mhit[0] && m_int[0]) |=> stat_r[0]) else $error("match flag not set");
   a_stop_halt: assert property (@(posedge pclk) disable iff (!presetn)
      do_stop |=> !ctrl_r[`MCT_CTRL_EN] ##1 !tick) else $error("stop did not halt");
   a_match_reset: assert property (@(posedge pclk) disable iff (!presetn)
      (do_rst && !do_cclr && !ctrl_r[`MCT_CTRL_RST] && !wr_count) |=> count_r == `MCT_ZERO32)
      else $error("reset on match failed");
   a_out_toggle: assert property (@(posedge pclk) disable iff (!presetn)
      (mhit[1] && !pwmc_r[1] && emr_r[3:2] == 2'h3) |=> mout_r[1] != $past(mout_r[1]))
      else $error("toggle missed");
   a_shadow_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (!shd_load && !$past(shd_load)) |-> $stable(match_r[1])) else $error("match changed");
   a_cap_clear: assert property (@(posedge pclk) disable iff (!presetn)
      do_cclr |=> count_r == `MCT_ZERO32 && pcount_r == `MCT_ZERO32)
      else $error("capture clear failed");
   a_pwm_period: assert property (@(posedge pclk) disable iff (!presetn)
      s_pwm_end |=> !mout_r[1]) else $error("pwm not cleared");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 irq_r == |($past(stat_nxt) & $past(mask_r))) else $error("irq mismatch");
   a_pre_wait: assert property (@(posedge pclk) disable iff (!presetn)
      s_pre_wait |=> count_r == $past(count_r) && pcount_r == $past(pcount_r) + `MCT_ONE32)
      else $error("prescaler step wrong");
   a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn)
      s_stop_only |=> count_r == $past(count_r)) else $error("count moved on stop");
   a_shadow_load: assert property (@(posedge pclk) disable iff (!presetn)
      s_shd_copy |=> match_r[1] == $past(shadow_r[1])) else $error("shadow not loaded");
   a_pwm_rise: assert property (@(posedge pclk) disable iff (!presetn)
      (pwmc_r[1] && mhit[1]) |=> mout_r[1]) else $error("pwm not set");
   a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
      (|ev) |=> (stat_r & $past(ev)) == $past(ev)) else $error("event flag lost");
   a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
      mask_r == 7'h00 |=> !irq_r) else $error("masked irq raised");
   // refused access answers with an error in its access phase
   a_bad_resp: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && bad) |=> pslverr) else $error("no error response");
   generate
      for (g = 1; g < `MCT_NUM_CAP; g++) begin : g_cchk
         a_cap_more: assert property (@(posedge pclk) disable iff (!presetn)
            cev[g] |=> cap_r[g] == $past(count_r)) else $error("capture value wrong");
      end
   endgenerate
endmodule
